/* hdl/etoi_buf2.sv */
// Purpose: two-entry valid/ready buffer for insertion words
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact, a stalled drain fills it
`timescale 1ns/10ps
`default_nettype none
module etoi_buf2 #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 2
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [$clog2(DEPTH+1)-1:0] cnt;
   } etoi_bst_s;
   etoi_bst_s st_r, st_nxt;
   logic push, pop;

   // handshakes
   assign o_in_ready = (st_r.cnt != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign o_out_valid = (st_r.cnt != '0);
   assign o_out_data = st_r.mem[0];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   // shift-out queue, head at entry 0
   always_comb begin
      st_nxt = st_r;
      if (pop) begin
         for (int k = 0; k < DEPTH - 1; k++) begin
            st_nxt.mem[k] = st_r.mem[k+1];
         end
      end
      if (push) begin
         st_nxt.mem[st_r.cnt - (pop ? 1'b1 : 1'b0)] = i_in_data;
      end
      st_nxt.cnt = st_r.cnt + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule // etoi_buf2
`default_nettype wire

/* hdl/etoi_pkg.sv */
// Purpose: shared constants and carriers of the transmit overhead insertion port
// Assumes: 56 overhead bit positions per frame, counted from the frame pulse edge
// Notes:   positions are overhead bit clock edge counts since the frame pulse
package etoi_pkg;
   // -----------------------------------------------------------------
   // overhead positions
   // -----------------------------------------------------------------
   localparam int OH_BITS = 56;
   localparam logic [5:0] POS_FIRST_INS = 6'h18;  // 24, first insertable bit
   localparam logic [5:0] POS_TRACE_LO = 6'h1e;   // 30, trail trace bit 1
   localparam logic [5:0] POS_MA = 6'h20;         // 32, far-end receive failure
   localparam logic [5:0] POS_MA_FEBE = 6'h21;    // 33, far-end block error
   localparam logic [5:0] POS_NR = 6'h28;         // 40
   localparam logic [5:0] POS_GC = 6'h30;         // 48
   localparam logic [5:0] POS_LAST = 6'h37;       // 55, last overhead bit
   localparam logic [5:0] POS_RESET = 6'h3f;      // outside the overhead
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int SYS_CLK_HZ = 50000000;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   localparam logic [5:0] POS_SYNC_LAG = 6'h02;   // link count when the resynced frame pulse shows
   localparam logic [5:0] LNK_RST_LEN = 6'h20;    // system cycles the link side is held in reset

   // byte sections of the overhead
   typedef enum logic [2:0] {
      ETOI_SEC_FA1 = 3'b000,
      ETOI_SEC_FA2 = 3'b001,
      ETOI_SEC_EM = 3'b010,
      ETOI_SEC_TR = 3'b011,
      ETOI_SEC_MA = 3'b100,
      ETOI_SEC_NR = 3'b101,
      ETOI_SEC_GC = 3'b110,
      ETOI_SEC_NONE = 3'b111
   } etoi_sec_e;

   // one accepted insertion, passed from link to system domain
   typedef struct packed {
      logic [5:0] pos;
      logic bit_val;
   } etoi_ins_s;
endpackage

/* hdl/etoi_port.sv */
// Purpose: transmit overhead insertion port, method 1 and method 2
// Assumes: framer core gives a frame pulse and a bit strobe per overhead bit
// Notes:   link logic runs on the overhead bit clock, the overlay on i_sys_clk
// Operation
// - positions 24..55 map msb first to trace, ma, nr and gc bytes
// - every position 24 through 55 accepts an external bit value
// - position 32 is far-end receive failure, 33 far-end block error
// - device samples strobe and data on the following falling edge
// - sampled strobe at insertable position replaces that outbound overhead bit
// - method one supplies a dedicated overhead bit clock to the terminal
// - method two samples on transmit input or receive output clock; here strobe and bit are resampled on i_sys_clk instead
// - method two signals: insert bit, input clock, frame pulse, slot strobe
// - positions 0..23 refused, positions 24..29 insertable
// - strobe at non-insertable position is ignored, own value sent
// - method two pulses slot strobe one clock before each overhead bit
`timescale 1ns/10ps
`default_nettype none
module etoi_port
   import etoi_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // framer core side (system domain)
   input wire logic i_method2,
   input wire logic i_core_frame,
   input wire logic i_core_oh_bit,
   input wire logic i_core_oh_val,
   output logic o_oh_val,
   output logic o_oh_inserted,
   // terminal side
   input wire logic i_overhead_bit_clock,
   output logic o_overhead_bit_clock,
   output logic o_overhead_frame_pulse,
   input wire logic i_overhead_insert_strobe,
   input wire logic i_overhead_insert_bit,
   output logic o_overhead_slot_strobe
);
   import etoi_pkg::*;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // insertable overhead positions, used by both domains
   function automatic logic pos_insertable(input logic [5:0] p);
      return (p >= POS_FIRST_INS) && (p <= POS_LAST);
   endfunction

   function automatic etoi_sec_e pos_section(input logic [5:0] p);
      if (p > POS_LAST) return ETOI_SEC_NONE;
      return etoi_sec_e'(p[5:3]);
   endfunction

   // -----------------------------------------------------------------
   // link domain: counter on rising, sampler on falling bit clock edges
   // -----------------------------------------------------------------
   // rising-edge side sees the frame pulse two edges after the terminal, through frm_sync
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] frm_sync;
      logic [5:0] pos;
   } etoi_cnt_s;
   etoi_cnt_s ck_r, ck_nxt;

   // falling-edge side holds the last accepted insertion
   typedef struct packed {
      logic tgl;
      etoi_ins_s word;
   } etoi_lnk_s;
   etoi_lnk_s lk_r, lk_nxt;

   logic lnk_rst_req;

   // frame pulse and link reset come from i_sys_clk and pass two flops;
   // the count restarts at the lag of that chain, so it matches the terminal
   always_comb begin
      ck_nxt = ck_r;
      ck_nxt.rst_sync = {ck_r.rst_sync[0], lnk_rst_req};
      ck_nxt.frm_sync = {ck_r.frm_sync[0], o_overhead_frame_pulse};
      if (ck_r.rst_sync[1]) begin
         ck_nxt.pos = POS_RESET;
      end else if (ck_r.frm_sync[1]) begin
         ck_nxt.pos = POS_SYNC_LAG;
      end else if (ck_r.pos != POS_RESET) begin
         ck_nxt.pos = ck_r.pos + 6'h01;
      end
   end

   always_ff @(posedge i_overhead_bit_clock) begin
      ck_r <= ck_nxt;
   end

   // the position changed half a bit clock earlier, so it is settled here
   always_comb begin
      lk_nxt = lk_r;
      if (ck_r.rst_sync[1]) begin
         lk_nxt = '0;
      end else if (i_overhead_insert_strobe && pos_insertable(ck_r.pos)) begin
         lk_nxt.word.pos = ck_r.pos;
         lk_nxt.word.bit_val = i_overhead_insert_bit;
         lk_nxt.tgl = ~lk_r.tgl;
      end
   end

   always_ff @(negedge i_overhead_bit_clock) begin
      lk_r <= lk_nxt;
   end

   // -----------------------------------------------------------------
   // system domain
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0] tgl_sync;
      logic tgl_d;
      logic [1:0] m2_ins_sync;
      logic [1:0] m2_bit_sync;
      logic [5:0] pos;
      logic [63:0] ovl_en;
      logic [63:0] ovl_val;
      logic frame;
      logic slot;
      logic oh_val;
      logic oh_ins;
      logic [2:0] div;
      logic ohclk;
      logic [5:0] rst_cnt;
      logic lnk_rst;
   } etoi_sys_s;
   etoi_sys_s st_r, st_nxt;

   logic ev_valid, ev_ready, bf_valid;
   etoi_ins_s ev_word, bf_word;
   logic [5:0] cur_pos;

   // crossing: toggle flagged event, word stable since the toggle changed
   assign ev_valid = st_r.tgl_sync[1] ^ st_r.tgl_d;
   assign ev_word = lk_r.word;

   etoi_buf2 #(
      .WIDTH($bits(etoi_ins_s)),
      .DEPTH(2)
   ) u_buf (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(ev_valid),
      .o_in_ready(ev_ready),
      .i_in_data(ev_word),
      .o_out_valid(bf_valid),
      .i_out_ready(1'b1),
      .o_out_data(bf_word)
   );

   // position of the bit the core is asking for now
   assign cur_pos = i_core_frame ? 6'h00 : st_r.pos;

   always_comb begin
      st_nxt = st_r;
      st_nxt.tgl_sync = {st_r.tgl_sync[0], lk_r.tgl};
      // hold the link side in reset long enough for a slow bit clock to catch it
      st_nxt.lnk_rst = (st_r.rst_cnt != LNK_RST_LEN);
      if (st_nxt.lnk_rst) begin
         st_nxt.rst_cnt = st_r.rst_cnt + 6'h01;
      end
      // the toggle is not trusted until the link side has left its reset
      if (st_r.lnk_rst) begin
         st_nxt.tgl_sync = 2'h0;
         st_nxt.tgl_d = 1'b0;
      end else if (ev_ready) begin
         // only retire the event when the buffer takes it, so no word is lost
         st_nxt.tgl_d = st_r.tgl_sync[1];
      end
      st_nxt.m2_ins_sync = {st_r.m2_ins_sync[0], i_overhead_insert_strobe};
      st_nxt.m2_bit_sync = {st_r.m2_bit_sync[0], i_overhead_insert_bit};
      st_nxt.div = st_r.div + 3'h1;
      if (st_r.div == 3'h7) begin
         st_nxt.ohclk = ~st_r.ohclk;
      end
      st_nxt.frame = i_core_frame;
      st_nxt.oh_ins = 1'b0;
      if (i_core_oh_bit) begin
         if (pos_section(cur_pos) != ETOI_SEC_NONE && st_r.ovl_en[cur_pos]) begin
            st_nxt.oh_val = st_r.ovl_val[cur_pos];
            st_nxt.oh_ins = 1'b1;
            st_nxt.ovl_en[cur_pos] = 1'b0;
         end else begin
            st_nxt.oh_val = i_core_oh_val;
         end
         st_nxt.pos = (cur_pos == POS_RESET) ? POS_RESET : cur_pos + 6'h01;
      end else if (i_core_frame) begin
         st_nxt.pos = 6'h00;
      end
      // overlay writes follow the consume above, so a word arriving now wins over the clear
      // overlay from accepted words
      if (bf_valid) begin
         st_nxt.ovl_en[bf_word.pos] = 1'b1;
         st_nxt.ovl_val[bf_word.pos] = bf_word.bit_val;
      end
      // method two sampled on system clock
      if (i_method2 && st_r.slot && st_r.m2_ins_sync[1] && pos_insertable(cur_pos)) begin
         st_nxt.ovl_en[cur_pos] = 1'b1;
         st_nxt.ovl_val[cur_pos] = st_r.m2_bit_sync[1];
      end
      // slot strobe ahead of bit
      // a long frame input counts once, for bit 0 only
      st_nxt.slot = i_method2 && (i_core_oh_bit || (i_core_frame && !st_r.frame)) && (st_nxt.pos <= POS_LAST);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         st_r <= '0;
         st_r.pos <= POS_RESET;
         st_r.lnk_rst <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs from flip-flops
   assign o_oh_val = st_r.oh_val;
   assign o_oh_inserted = st_r.oh_ins;
   assign o_overhead_frame_pulse = st_r.frame;
   assign o_overhead_slot_strobe = st_r.slot;
   assign o_overhead_bit_clock = st_r.ohclk;
   // link reset request, stretched in this domain
   assign lnk_rst_req = st_r.lnk_rst;
endmodule // etoi_port
`default_nettype wire

/* sim/etoi_port_chk.sv */
// Purpose: port checker of the overhead insertion port
// Assumes: core bits spaced apart, frame input a few cycles wide
// Notes: sees top ports only
`timescale 1ns/10ps
`default_nettype none
module etoi_port_chk (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_method2,
   input wire logic i_core_frame,
   input wire logic i_core_oh_bit,
   input wire logic i_core_oh_val,
   input wire logic o_oh_val,
   input wire logic o_oh_inserted,
   input wire logic o_overhead_bit_clock,
   input wire logic o_overhead_frame_pulse,
   input wire logic o_overhead_slot_strobe
);
   logic [6:0] pos_r;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // position of the next core bit, 7f after reset until a frame is seen or a core bit wraps it to 00
   always_ff @(posedge i_sys_clk) begin
      pos_r <= i_sys_rst ? 7'h7f : (i_core_frame ? 7'h00 : pos_r + {6'h00, i_core_oh_bit});
   end
   a_ins_after_bit: assert property (o_oh_inserted |-> $past(i_core_oh_bit))
      else $error("insert without core bit");
   a_own_value: assert property ($past(i_core_oh_bit) && !o_oh_inserted |->
      o_oh_val == $past(i_core_oh_val)) else $error("own value lost");
   a_refuse_pos: assert property (i_core_oh_bit && (pos_r < 7'h18 || pos_r > 7'h37) |=> !o_oh_inserted)
      else $error("insert at refused place");
   a_ins_single: assert property (o_oh_inserted |=> !o_oh_inserted)
      else $error("insert flag too long");
   a_frame_copy: assert property ($rose(i_core_frame) |=> o_overhead_frame_pulse)
      else $error("frame pulse missing");
   a_clk_half: assert property ($changed(o_overhead_bit_clock) |=>
      $stable(o_overhead_bit_clock) [*7] ##1 $changed(o_overhead_bit_clock)) else $error("bad bit clock");
   a_slot_single: assert property (o_overhead_slot_strobe |=> !o_overhead_slot_strobe)
      else $error("slot strobe too long");
   a_m1_no_slot: assert property (!i_method2 [*8] |-> !o_overhead_slot_strobe)
      else $error("slot strobe in method 1");
endmodule // etoi_port_chk
bind etoi_port etoi_port_chk etoi_port_chk_inst (.*);
`default_nettype wire

/* sim/etoi_term.sv */
// Purpose: terminal model inserting overhead bits
// Assumes: counts rising edges of the overhead bit clock
// Notes: inserts n bits from a target position, values alternate
`timescale 1ns/10ps
`default_nettype none
module etoi_term (
   input wire logic i_clk,
   input wire logic i_frame,
   input wire logic i_en,
   input wire logic [5:0] i_pos,
   input wire logic [1:0] i_n,
   input wire logic i_val,
   output logic o_ins,
   output logic o_bit
);
   logic [6:0] cnt_r = 7'h7f;
   logic [6:0] cnt_nxt;
   logic hit;
   assign cnt_nxt = i_frame ? 7'h00 : cnt_r + {6'h00, cnt_r != 7'h7f};
   assign hit = i_en && (cnt_nxt - {1'b0, i_pos}) < {5'h00, i_n};
   // raise, hold, drop
   // a released data line toggles so stale data never looks valid
   always @(posedge i_clk) begin
      cnt_r <= cnt_nxt;
      o_ins <= hit;
      o_bit <= hit ? i_val ^ cnt_nxt[0] ^ i_pos[0] : ~o_bit;
   end
endmodule // etoi_term
`default_nettype wire

/* sim/tb_etoi_port.sv */
// Purpose: self-checking bench of the overhead insertion port
// Assumes: free 80 ns link clock, one core bit per 16 system cycles
// Notes: method 2 runs with the terminal idle, judged by slot strobe count and own values
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_etoi_port;
   import etoi_pkg::*;
   logic clk = 1'b0, rst = 1'b1, m2 = 1'b0, frame = 1'b0, obit = 1'b0, oval = 1'b0, lclk = 1'b0;
   logic t_en = 1'b0, t_val = 1'b0, ins;
   logic [5:0] t_pos = 6'h00;
   logic [1:0] t_n = 2'h0;
   logic val_out, ins_out, clk_out, fpulse, strb, ibit, slot;
   int bad_count = 0, n_compared = 0, slots = 0, ohclks = 0;
   etoi_port etoi_port_inst (.i_sys_clk(clk), .i_sys_rst(rst), .i_method2(m2), .i_core_frame(frame),
      .i_core_oh_bit(obit), .i_core_oh_val(oval), .o_oh_val(val_out), .o_oh_inserted(ins_out),
      .i_overhead_bit_clock(lclk), .o_overhead_bit_clock(clk_out), .o_overhead_frame_pulse(fpulse),
      .i_overhead_insert_strobe(strb), .i_overhead_insert_bit(ibit), .o_overhead_slot_strobe(slot));
   etoi_term etoi_term_inst (.i_clk(lclk), .i_frame(fpulse), .i_en(t_en), .i_pos(t_pos), .i_n(t_n),
      .i_val(t_val), .o_ins(strb), .o_bit(ibit));
   always #10 clk = ~clk;
   // offset keeps link edges away from system edges
   initial begin
      #13;
      forever #40 lclk = ~lclk;
   end
   always @(negedge clk) if (slot === 1'b1) slots++;
   // rising edges of the port's output bit clock, clk_out; the terminal runs on lclk
   always @(posedge clk_out) ohclks++;
   // one frame of core bits, each outgoing bit checked a cycle later
   task automatic run_frame(input logic mode2, en, input logic [5:0] pos, input logic [1:0] n, input logic val);
      int p;
      {m2, t_en, t_pos, t_n, t_val} = {mode2, en, pos, n, val};
      oval = ~val;
      repeat (16) @(negedge clk);
      slots = 0;
      frame = 1'b1;
      repeat (4) @(negedge clk);
      frame = 1'b0;
      ohclks = 0;
      for (p = 0; p < OH_BITS; p++) begin
         obit = 1'b1;
         @(negedge clk);
         obit = 1'b0;
         ins = en && p >= POS_FIRST_INS && p <= POS_LAST && p >= pos && p < pos + n;
         `CHK(ins_out, ins)
         `CHK(val_out, ins ? val ^ p[0] ^ pos[0] : ~val)
         repeat (15) @(negedge clk);
      end
      `CHK(slots, mode2 ? 56 : 0)
      `CHK(ohclks, 56)
   endtask
   task automatic sc_ferf;
      run_frame(1'b0, 1'b1, POS_MA, 2'h1, 1'b1);
   endtask
   task automatic sc_low_edge;
      run_frame(1'b0, 1'b1, 6'h16, 2'h3, 1'b1);
   endtask
   task automatic sc_trace_ma;
      run_frame(1'b0, 1'b1, 6'h1f, 2'h3, 1'b0);
   endtask
   task automatic sc_high_edge;
      run_frame(1'b0, 1'b1, 6'h36, 2'h3, 1'b1);
   endtask
   task automatic sc_method2;
      run_frame(1'b1, 1'b0, POS_GC, 2'h1, 1'b1);
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      // the link side stays in reset for a while after the system reset
      repeat (int'(LNK_RST_LEN) * 2) @(negedge clk);
      sc_ferf();
      sc_low_edge();
      sc_trace_ma();
      sc_high_edge();
      sc_method2();
      finish_test();
   end
endmodule // tb_etoi_port
`default_nettype wire
